// file: motor_map.svh
`ifndef MOTOR_MAP_SVH
`define MOTOR_MAP_SVH

// ----------------------------------------------------------------------------
// Timing and scaling
// ----------------------------------------------------------------------------
`define CLK_RATE_HZ 20000000
`define MS_PER_S 1000
`define STEPS_PER_REV 500
`define SEC_PER_MIN 60
`define RAMP_REF_RPM 32'h0000_0BB8
`define SLOW_HOME_RPM 13'h003C

// ----------------------------------------------------------------------------
// Setting limits and reset values
// ----------------------------------------------------------------------------
`define SPEED_MAX_RPM 13'h0FA0
`define RAMP_MAX_MS 15'h7530
`define HOME_SPEED_DEF 13'h012C
`define HOME_RAMP_DEF 15'h0064
`define HOME_DIR_DEF 1'h1
`define POS_DEF 24'h00_0000
`define DATA_SPEED_DEF 13'h0000
`define DATA_RAMP_DEF 15'h0064

// ----------------------------------------------------------------------------
// Field sizes
// ----------------------------------------------------------------------------
`define SPEED_W 13
`define RAMP_W 15
`define POS_W 24
`define SEL_W 4
`define DATA_SETS 16

`endif

// file: motor_pkg.sv
package motor_pkg;

    // Controller states.
    typedef enum logic [2:0] {
        idle_st,
        seek_st,
        seek_stop_st,
        offset_st,
        preset_st,
        preset_hold_st,
        run_st
    } state_type;

endpackage : motor_pkg

// file: op_data_mem.sv
`timescale 1ns/1ps
`include "motor_map.svh"

module op_data_mem #(
    parameter int DEPTH = `DATA_SETS
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic wr_en,
    input wire logic [`SEL_W-1:0] wr_addr,
    input wire logic [`SPEED_W-1:0] wr_speed,
    input wire logic [`RAMP_W-1:0] wr_acc,
    input wire logic [`RAMP_W-1:0] wr_dec,
    input wire logic [`SEL_W-1:0] rd_addr,
    output logic [`SPEED_W-1:0] rd_speed,
    output logic [`RAMP_W-1:0] rd_acc,
    output logic [`RAMP_W-1:0] rd_dec
);

    initial begin
        if (DEPTH != (1 << `SEL_W)) $error("DEPTH must match the select width");
    end

    logic [`SPEED_W-1:0] speed_mem [DEPTH];
    logic [`RAMP_W-1:0] acc_mem [DEPTH];
    logic [`RAMP_W-1:0] dec_mem [DEPTH];

    // Storage with write port; every set starts at its reset value.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < DEPTH; i++) begin
                speed_mem[i] <= `DATA_SPEED_DEF;
                acc_mem[i] <= `DATA_RAMP_DEF;
                dec_mem[i] <= `DATA_RAMP_DEF;
            end
        end else if (wr_en) begin
            speed_mem[wr_addr] <= wr_speed;
            acc_mem[wr_addr] <= wr_acc;
            dec_mem[wr_addr] <= wr_dec;
        end
    end

    // Registered read of the selected set.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rd_speed <= `DATA_SPEED_DEF;
            rd_acc <= `DATA_RAMP_DEF;
            rd_dec <= `DATA_RAMP_DEF;
        end else begin
            rd_speed <= speed_mem[rd_addr];
            rd_acc <= acc_mem[rd_addr];
            rd_dec <= dec_mem[rd_addr];
        end
    end

endmodule : op_data_mem

// file: speed_ramp.sv
`timescale 1ns/1ps
`include "motor_map.svh"

module speed_ramp #(
    parameter int CYC_PER_MS = `CLK_RATE_HZ / `MS_PER_S
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic [`SPEED_W-1:0] target,
    input wire logic [`RAMP_W-1:0] acc_ms,
    input wire logic [`RAMP_W-1:0] dec_ms,
    input wire logic direct,
    input wire logic halt,
    output logic [`SPEED_W-1:0] speed
);

    initial begin
        if (CYC_PER_MS < 3000) $error("CYC_PER_MS must be at least 3000");
    end

    // Ramp times are referred to a swing of 3000 r/min.
    logic [31:0] acc;
    wire up = target > speed;
    wire down = target < speed;
    wire [`RAMP_W-1:0] ms = up ? acc_ms : dec_ms;
    wire [31:0] limit = 32'(ms) * 32'(CYC_PER_MS);
    wire [31:0] next_acc = acc + `RAMP_REF_RPM;
    wire step = next_acc >= limit;

    // One r/min per overflow of the rate accumulator.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            speed <= '0;
            acc <= '0;
        end else if (halt) begin
            speed <= '0;
            acc <= '0;
        end else if (direct || (ms == '0)) begin
            speed <= target;
            acc <= '0;
        end else if (up || down) begin
            acc <= step ? next_acc - limit : next_acc;
            if (step) speed <= up ? speed + 1'b1 : speed - 1'b1;
        end else begin
            acc <= '0;
        end
    end

endmodule : speed_ramp

// file: homing_run_ctrl.sv
`timescale 1ns/1ps
`include "motor_map.svh"
// Operation
// RL1 - Offset move after homing sets electrical home
// RL2 - Zero offset: electrical equals mechanical home
// RL3 - Signed 24-bit home offset, 0.72 degree steps
// RL4 - Position zero after homing, preset value otherwise
// RL5 - Homing speed 0 to 4000, default 300
// RL6 - Homing ramp 0 to 30 s, default 0.1
// RL7 - Direction setting 1 positive, 0 negative
// RL8 - Slow homing speed applied directly
// RL9 - Host holds homing request until ready drops
// RL10 - Homing-complete asserted when homing finishes
// RL11 - No homing while free or stop asserted
// RL12 - Preset loads command position with setting
// RL13 - Preset ignored while moving or alarmed
// RL14 - Signed 24-bit preset position, 0.72 degree steps
// RL15 - Homing-complete asserted after preset processing
// RL16 - Host holds preset until homing-complete seen
// RL17 - Nonzero preset never asserts homing-complete
// RL18 - Run continues while a run input holds
// RL19 - Run speed follows selected data set
// RL20 - Release decelerates; same input reaccelerates
// RL21 - Both run inputs decelerate to stop
// RL22 - Sixteen data sets numbered zero to fifteen
// RL23 - Set speed 0 to 4000, ramps referred 3000
// RL24 - Four select inputs form binary set number
// RL25 - Host waits 10 ms after selection change
// RL26 - Ready drops on run, returns after stop
// RL27 - Home sensor rising edge stops seek
// RL28 - Positive input turns positive, negative reverse
// RL29 - Ready low during homing or preset

module homing_run_ctrl #(
    parameter int CLK_HZ = `CLK_RATE_HZ,
    parameter int CYC_PER_MS = CLK_HZ / `MS_PER_S
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic home_in,
    input wire logic preset_in,
    input wire logic run_positive_in,
    input wire logic run_negative_in,
    input wire logic data_select_bit0,
    input wire logic data_select_bit1,
    input wire logic data_select_bit2,
    input wire logic data_select_bit3,
    input wire logic free_in,
    input wire logic stop_in,
    input wire logic alarm_in,
    input wire logic home_sensor_in,
    input wire logic [`SPEED_W-1:0] home_speed,
    input wire logic [`RAMP_W-1:0] home_ramp_ms,
    input wire logic signed [`POS_W-1:0] home_offset,
    input wire logic home_dir,
    input wire logic signed [`POS_W-1:0] preset_position,
    input wire logic data_wr_en,
    input wire logic [`SEL_W-1:0] data_wr_addr,
    input wire logic [`SPEED_W-1:0] data_wr_speed,
    input wire logic [`RAMP_W-1:0] data_wr_acc,
    input wire logic [`RAMP_W-1:0] data_wr_dec,
    output logic ready,
    output logic home_done,
    output logic moving,
    output logic dir_out,
    output logic step_out,
    output logic signed [`POS_W-1:0] command_position,
    output logic [`SPEED_W-1:0] motor_speed
);

    initial begin
        if (CLK_HZ < 3000 * `MS_PER_S) $error("CLK_HZ too low for the ramp");
    end

    // ------------------------------------------------------------------------
    // Data set selection and ramp
    // ------------------------------------------------------------------------
    motor_pkg::state_type state;
    motor_pkg::state_type next_state;
    logic sensor_q;
    logic [31:0] step_acc;
    logic [`POS_W-1:0] offset_left;
    logic [`SPEED_W-1:0] set_speed;
    logic [`RAMP_W-1:0] set_acc;
    logic [`RAMP_W-1:0] set_dec;

    // The select inputs read as one binary set number.
    wire [`SEL_W-1:0] sel = {data_select_bit3, data_select_bit2, data_select_bit1, data_select_bit0}; // RL24

    op_data_mem #(.DEPTH(`DATA_SETS)) data_mem ( // RL22
        .ref_clk(ref_clk),
        .rstn(rstn),
        .wr_en(data_wr_en),
        .wr_addr(data_wr_addr),
        .wr_speed(data_wr_speed),
        .wr_acc(data_wr_acc),
        .wr_dec(data_wr_dec),
        .rd_addr(sel),
        .rd_speed(set_speed),
        .rd_acc(set_acc),
        .rd_dec(set_dec)
    );

    // Homing speed, homing ramp and set speed above their range are clipped to the documented limits.
    wire [`SPEED_W-1:0] home_spd = (home_speed > `SPEED_MAX_RPM) ? `SPEED_MAX_RPM : home_speed; // RL5
    wire [`RAMP_W-1:0] home_ms = (home_ramp_ms > `RAMP_MAX_MS) ? `RAMP_MAX_MS : home_ramp_ms; // RL6
    wire [`SPEED_W-1:0] run_spd = (set_speed > `SPEED_MAX_RPM) ? `SPEED_MAX_RPM : set_speed; // RL23
    wire homing = (state == motor_pkg::seek_st) || (state == motor_pkg::offset_st);
    wire both_run = run_positive_in && run_negative_in;
    wire one_run = run_positive_in ^ run_negative_in;
    wire want_pos = run_positive_in && !run_negative_in; // RL28
    wire sensor_rise = home_sensor_in && !sensor_q; // RL27
    wire stopped = (motor_speed == '0);
    wire halt_now = homing && (free_in || stop_in);
    wire offset_end = (state == motor_pkg::offset_st) && (offset_left == '0);
    wire home_start = home_in && !free_in && !stop_in; // RL11
    wire preset_ok = preset_in && !moving && !alarm_in; // RL13
    wire run_start = run_positive_in || run_negative_in;
    wire same_dir = stopped || (want_pos == dir_out);

    // Target speed per state; a run holds only while one input matches.
    wire [`SPEED_W-1:0] run_target = (one_run && same_dir) ? run_spd : '0; // RL19 RL20 RL21
    wire [`SPEED_W-1:0] target = homing ? home_spd : (state == motor_pkg::run_st) ? run_target : '0;
    wire [`RAMP_W-1:0] acc_ms = (state == motor_pkg::run_st) ? set_acc : home_ms;
    wire [`RAMP_W-1:0] dec_ms = (state == motor_pkg::run_st) ? set_dec : home_ms;
    // Slow homing skips the ramp on the sensor stop as well as on the seek.
    wire slow_home = (homing || (state == motor_pkg::seek_stop_st)) && (home_spd <= `SLOW_HOME_RPM); // RL8

    speed_ramp #(.CYC_PER_MS(CYC_PER_MS)) ramp (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .target(target),
        .acc_ms(acc_ms),
        .dec_ms(dec_ms),
        .direct(slow_home),
        .halt(offset_end || halt_now),
        .speed(motor_speed)
    );

    // ------------------------------------------------------------------------
    // Step generation
    // ------------------------------------------------------------------------
    localparam logic [31:0] STEP_LIMIT = 32'(`SEC_PER_MIN) * 32'(CLK_HZ);
    wire [31:0] next_step_acc = step_acc + 32'(motor_speed) * 32'(`STEPS_PER_REV);
    wire step_hit = next_step_acc >= STEP_LIMIT;

    // Speed in r/min becomes 500 steps per revolution.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            step_acc <= '0;
            step_out <= 1'b0;
        end else begin
            step_acc <= step_hit ? next_step_acc - STEP_LIMIT : next_step_acc;
            step_out <= step_hit;
        end
    end

    // ------------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------------
    // Next state of the homing, preset and run sequencer.
    always_comb begin
        next_state = state;
        unique case (state)
            motor_pkg::idle_st: begin
                if (home_start) next_state = motor_pkg::seek_st;
                else if (preset_ok) next_state = motor_pkg::preset_st;
                else if (run_start) next_state = motor_pkg::run_st; // RL18
            end
            motor_pkg::seek_st: begin
                if (halt_now) next_state = motor_pkg::idle_st;
                else if (sensor_rise) next_state = motor_pkg::seek_stop_st; // RL27
            end
            motor_pkg::seek_stop_st: begin
                if (stopped && (home_offset != '0)) next_state = motor_pkg::offset_st; // RL1
                else if (stopped) next_state = motor_pkg::idle_st; // RL2
            end
            motor_pkg::offset_st: begin
                if (offset_end || halt_now) next_state = motor_pkg::idle_st;
            end
            motor_pkg::preset_st: next_state = motor_pkg::preset_hold_st;
            motor_pkg::preset_hold_st: begin
                if (!preset_in) next_state = motor_pkg::idle_st;
            end
            motor_pkg::run_st: begin
                if (stopped && !run_start) next_state = motor_pkg::idle_st; // RL26
            end
            default: next_state = motor_pkg::idle_st;
        endcase
    end

    // Homing ends at rest with no offset, or when the offset count runs out.
    wire home_finish = ((state == motor_pkg::seek_stop_st) && stopped && (home_offset == '0)) || offset_end;
    wire [`POS_W-1:0] offset_mag = home_offset[`POS_W-1] ? `POS_W'(-home_offset) : home_offset; // RL3

    // State, sensor edge and offset countdown.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state <= motor_pkg::idle_st;
            sensor_q <= 1'b0;
            offset_left <= `POS_DEF;
        end else begin
            state <= next_state;
            sensor_q <= home_sensor_in;
            if (state == motor_pkg::seek_stop_st) offset_left <= offset_mag;
            else if (state == motor_pkg::offset_st && step_out && offset_left != '0) offset_left <= offset_left - 1'b1;
        end
    end

    // Direction: homing setting, offset sign, or run input when at rest.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            dir_out <= `HOME_DIR_DEF;
        end else if (state == motor_pkg::idle_st && home_start) begin
            dir_out <= home_dir; // RL7
        end else if (state == motor_pkg::seek_stop_st && stopped) begin
            dir_out <= !home_offset[`POS_W-1]; // RL1
        end else if ((state == motor_pkg::run_st || next_state == motor_pkg::run_st) && stopped && one_run) begin
            dir_out <= want_pos; // RL28
        end
    end

    // Command position tracks steps; homing zeroes it, preset loads it.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            command_position <= `POS_DEF;
        end else if (home_finish) begin
            command_position <= `POS_DEF; // RL4
        end else if (state == motor_pkg::preset_st) begin
            command_position <= preset_position; // RL12 RL14
        end else if (step_out) begin
            command_position <= dir_out ? command_position + 1'b1 : command_position - 1'b1;
        end
    end

    // Homing-complete flag and motion status.
    // A preset that is taken clears the flag; a zero preset then sets it again, so the host never sees a stale one.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            home_done <= 1'b0;
            moving <= 1'b0;
        end else begin
            moving <= (next_state != motor_pkg::idle_st) && (next_state != motor_pkg::preset_st) &&
                (next_state != motor_pkg::preset_hold_st);
            if (home_finish) home_done <= 1'b1; // RL10
            else if (state == motor_pkg::preset_st) home_done <= (preset_position == '0); // RL15 RL17
            else if (state == motor_pkg::idle_st && (home_start || preset_ok || run_start)) home_done <= 1'b0;
        end
    end

    // Ready only at rest in the idle state.
    assign ready = (state == motor_pkg::idle_st); // RL26 RL29

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    ready_rest_a: assert property (@(posedge ref_clk) disable iff (!rstn) // RL26
        ready |-> !moving && !homing)
        else $error("ready while busy");
    home_block_a: assert property (@(posedge ref_clk) disable iff (!rstn) // RL11
        ready && (free_in || stop_in) |=> state != motor_pkg::seek_st)
        else $error("homing started while free or stop");
    home_dir_a: assert property (@(posedge ref_clk) disable iff (!rstn) // RL7
        ready && home_start |=> dir_out == $past(home_dir))
        else $error("homing direction wrong");
    home_zero_a: assert property (@(posedge ref_clk) disable iff (!rstn) // RL4
        home_finish |=> command_position == '0 && home_done && ready)
        else $error("homing did not zero position");
    preset_load_a: assert property (@(posedge ref_clk) disable iff (!rstn) // RL12
        ready && preset_ok && !home_start |=> ##1 command_position == $past(preset_position, 2))
        else $error("preset value not loaded");
    preset_block_a: assert property (@(posedge ref_clk) disable iff (!rstn) // RL13
        ready && preset_in && alarm_in |=> state != motor_pkg::preset_st)
        else $error("preset taken during alarm");
    preset_flag_a: assert property (@(posedge ref_clk) disable iff (!rstn) // RL17
        state == motor_pkg::preset_st && preset_position != '0 |=> !home_done)
        else $error("homing-complete after nonzero preset");
    both_stop_a: assert property (@(posedge ref_clk) disable iff (!rstn) // RL21
        state == motor_pkg::run_st && both_run && !stopped |=> motor_speed <= $past(motor_speed))
        else $error("speed rose with both inputs");
    run_hold_a: assert property (@(posedge ref_clk) disable iff (!rstn) // RL18
        state == motor_pkg::run_st && run_start |=> state == motor_pkg::run_st)
        else $error("run left while input held");
    slow_home_a: assert property (@(posedge ref_clk) disable iff (!rstn) // RL8
        state == motor_pkg::seek_st && $stable(state) && slow_home && !halt_now |=> motor_speed == $past(home_spd))
        else $error("slow homing speed not applied");
    preset_done_a: assert property (@(posedge ref_clk) disable iff (!rstn) // RL15
        state == motor_pkg::preset_st && preset_position == '0 |=> home_done)
        else $error("homing-complete missing after zero preset");
    slow_stop_a: assert property (@(posedge ref_clk) disable iff (!rstn) // RL8
        state == motor_pkg::seek_stop_st && slow_home |=> stopped)
        else $error("slow homing did not stop at once");

    home_cov: cover property (@(posedge ref_clk) disable iff (!rstn) home_finish);
    preset_cov: cover property (@(posedge ref_clk) disable iff (!rstn)
        state == motor_pkg::preset_st ##1 home_done);
    run_cov: cover property (@(posedge ref_clk) disable iff (!rstn)
        state == motor_pkg::run_st && motor_speed != '0 ##1 !run_start);
    // Offset move and refused homing start are covered as well.
    offset_cov: cover property (@(posedge ref_clk) disable iff (!rstn)
        state == motor_pkg::offset_st && step_out);
    refuse_cov: cover property (@(posedge ref_clk) disable iff (!rstn)
        ready && home_in && (free_in || stop_in));

endmodule : homing_run_ctrl

// file: host_model.sv
`timescale 1ns/1ps

// --------------------------------------------------------------
// Host controller model
// --------------------------------------------------------------
module host_model (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic go_home,
    input wire logic go_preset,
    input wire logic ready,
    input wire logic home_done,
    output logic home_in,
    output logic preset_in
);
    logic preset_spent;

    // Homing is raised only while ready and dropped once ready has fallen.
    // A finished preset is not raised again until the request is withdrawn.
    // Preset is raised on ready and held until homing-complete shows after ready fell.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            home_in <= 1'b0;
            preset_in <= 1'b0;
            preset_spent <= 1'b0;
        end else begin
            home_in <= go_home & ready;
            preset_in <= go_preset & ~preset_spent & (preset_in ? ~(home_done & ~ready) : ready);
            preset_spent <= go_preset & (preset_spent | (preset_in & home_done & ~ready));
        end
    end
endmodule : host_model

// file: homing_run_ctrl_tb_top.sv
`timescale 1ns/1ps
`include "motor_map.svh"

module homing_run_ctrl_tb_top;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic go_home = 1'b0, go_preset = 1'b0, home_in, preset_in, home_sensor_in = 1'b0;
    logic run_positive_in = 1'b0, run_negative_in = 1'b0, free_in = 1'b0, stop_in = 1'b0;
    logic alarm_in = 1'b0, home_dir = 1'b1, data_wr_en = 1'b0;
    logic [3:0] sel = 4'h0, data_wr_addr = 4'h0;
    logic [`SPEED_W-1:0] home_speed = 13'h012C, data_wr_speed = 13'h0000, motor_speed;
    logic [`RAMP_W-1:0] home_ramp_ms = 15'h0000, data_wr_acc = 15'h0000, data_wr_dec = 15'h0000;
    logic signed [`POS_W-1:0] home_offset = 24'h00_0000, preset_position = 24'h00_0000, command_position;
    logic ready, home_done, moving, dir_out, step_out;
    int fail_count = 0, total_checks = 0, i, steps;

    // Free-running clock at 50 ns period.
    always #25 ref_clk = ~ref_clk;

    homing_run_ctrl #(.CLK_HZ(3000000)) u_homing_run_ctrl (.ref_clk(ref_clk), .rstn(rstn),
        .home_in(home_in), .preset_in(preset_in), .run_positive_in(run_positive_in),
        .run_negative_in(run_negative_in), .data_select_bit0(sel[0]), .data_select_bit1(sel[1]),
        .data_select_bit2(sel[2]), .data_select_bit3(sel[3]), .free_in(free_in), .stop_in(stop_in),
        .alarm_in(alarm_in), .home_sensor_in(home_sensor_in), .home_speed(home_speed),
        .home_ramp_ms(home_ramp_ms), .home_offset(home_offset), .home_dir(home_dir),
        .preset_position(preset_position), .data_wr_en(data_wr_en), .data_wr_addr(data_wr_addr),
        .data_wr_speed(data_wr_speed), .data_wr_acc(data_wr_acc), .data_wr_dec(data_wr_dec),
        .ready(ready), .home_done(home_done), .moving(moving), .dir_out(dir_out),
        .step_out(step_out), .command_position(command_position), .motor_speed(motor_speed));

    host_model u_host_model (.ref_clk(ref_clk), .rstn(rstn), .go_home(go_home), .go_preset(go_preset),
        .ready(ready), .home_done(home_done), .home_in(home_in), .preset_in(preset_in));

    // --------------------------------------------------------------
    // Helpers
    // --------------------------------------------------------------
    task automatic give_verdict();
        $display("checks=%0d mismatches=%0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : give_verdict

    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : tick

    task automatic wait_ready(input logic v, input int lim);
        for (i = 0; i < lim && ready !== v; i++) tick(1);
    endtask : wait_ready

    task automatic wait_speed(input logic [12:0] v, input int lim);
        for (i = 0; i < lim && motor_speed !== v; i++) tick(1);
    endtask : wait_speed

    task automatic write_set(input logic [3:0] a, input logic [12:0] s, input logic [14:0] d);
        @(posedge ref_clk);
        data_wr_en <= 1'b1;
        data_wr_addr <= a;
        data_wr_speed <= s;
        data_wr_dec <= d;
        @(posedge ref_clk);
        data_wr_en <= 1'b0;
    endtask : write_set

    // --------------------------------------------------------------
    // Scenarios
    // --------------------------------------------------------------
    task automatic t_home(input logic dir, input logic [12:0] spd, input logic [23:0] ofs, input int exp_steps);
        @(posedge ref_clk);
        home_dir <= dir;
        home_speed <= spd;
        home_offset <= ofs;
        home_ramp_ms <= (spd > 13'h003C) ? 15'h0000 : 15'h03E8;
        go_home <= 1'b1;
        tick(2);
        wait_ready(1'b0, 10);
        go_home <= 1'b0;
        tick(20);
        check(dir_out, dir);
        check(motor_speed, spd);
        check({ready, moving}, 2'h1);
        @(posedge ref_clk);
        home_sensor_in <= 1'b1;
        tick(2);
        wait_speed(13'h0000, 30);
        steps = 0;
        for (i = 0; i < 40000 && home_done !== 1'b1; i++) begin
            tick(1);
            steps += (step_out === 1'b1);
        end
        check(home_done, 1'b1);
        check(steps, exp_steps);
        check(command_position, 24'h00_0000);
        check(ready, 1'b1);
        home_sensor_in <= 1'b0;
        $display("homing test done");
    endtask : t_home

    task automatic t_refuse_home();
        for (int k = 0; k < 2; k++) begin
            @(posedge ref_clk);
            free_in <= (k == 0);
            stop_in <= (k == 1);
            go_home <= 1'b1;
            tick(10);
            check({ready, moving}, 2'h2);
            go_home <= 1'b0;
            tick(2);
            free_in <= 1'b0;
            stop_in <= 1'b0;
        end
        $display("homing refusal test done");
    endtask : t_refuse_home

    task automatic t_preset(input logic [23:0] p, input logic al, input logic [23:0] exp_pos, input logic exp_done);
        @(posedge ref_clk);
        preset_position <= p;
        alarm_in <= al;
        go_preset <= 1'b1;
        tick(10);
        check(command_position, exp_pos);
        check(home_done, exp_done);
        go_preset <= 1'b0;
        tick(2);
        alarm_in <= 1'b0;
        wait_ready(1'b1, 10);
        check(ready, 1'b1);
        check(command_position, exp_pos);
        $display("preset test done");
    endtask : t_preset

    task automatic t_run();
        write_set(4'h5, 13'h00C8, 15'h0000);
        write_set(4'hA, 13'h0190, 15'h0001);
        write_set(4'hF, 13'h0064, 15'h0000);
        sel <= 4'h5;
        tick(10 * 3000);
        run_positive_in <= 1'b1;
        wait_speed(13'h00C8, 50);
        check(motor_speed, 13'h00C8);
        check({dir_out, moving, ready}, 3'h6);
        sel <= 4'hA;
        wait_speed(13'h0190, 50);
        check(motor_speed, 13'h0190);
        run_positive_in <= 1'b0;
        tick(20);
        check(motor_speed < 13'h0190 && motor_speed > 13'h0000, 1'b1);
        run_positive_in <= 1'b1;
        wait_speed(13'h0190, 50);
        check(motor_speed, 13'h0190);
        run_negative_in <= 1'b1;
        wait_speed(13'h0000, 600);
        check({motor_speed, ready}, 14'h0000);
        run_positive_in <= 1'b0;
        run_negative_in <= 1'b0;
        tick(2);
        wait_ready(1'b1, 10);
        check(ready, 1'b1);
        run_negative_in <= 1'b1;
        wait_speed(13'h0190, 50);
        check(dir_out, 1'b0);
        sel <= 4'hF;
        wait_speed(13'h0064, 600);
        check(motor_speed, 13'h0064);
        run_negative_in <= 1'b0;
        wait_ready(1'b1, 600);
        check(ready, 1'b1);
        $display("run test done");
    endtask : t_run

    // Main sequence: reset for three cycles, then every scenario in turn.
    initial begin
        repeat (3) @(posedge ref_clk);
        rstn <= 1'b1;
        tick(1);
        check({ready, home_done, moving, motor_speed}, 16'h8000);
        t_home(1'b0, 13'h012C, 24'h00_0000, 0);
        t_home(1'b1, 13'h003C, 24'h00_0003, 3);
        t_refuse_home();
        t_preset(24'h00_0123, 1'b0, 24'h00_0123, 1'b0);
        t_preset(24'hFF_FFFE, 1'b1, 24'h00_0123, 1'b0);
        t_preset(24'h00_0000, 1'b0, 24'h00_0000, 1'b1);
        t_run();
        give_verdict();
    end

    // Watchdog that cuts a hang short.
    initial begin
        repeat (80000) @(posedge ref_clk);
        fail_count++;
        give_verdict();
    end
endmodule : homing_run_ctrl_tb_top
